// [hw/usr_regs.sv]
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - Overrun when char arrives with FIFO full
// - Parity bit follows head character tag
// - Framing bit follows head character tag
// - Long low line loads one break
// - Holding-empty flag per FIFO mode
// - Idle only when holding and shift empty
// - FIFO error while any errored byte
// - Deltas on CTS DSR CD changes
// - Ring delta only on ring end
// - CTS high pauses transmitter between characters
// - Status levels are complemented pins
// - Loopback mirrors modem control bits
// - Feature bits disable transmitter or receiver
// - Feature bit six selects nine-bit mode
// - Feature bit seven selects fast infrared
// - Scratch keeps value, resets to FF
// - Swap redirects scratch writes and reads
// - Mode bits pick level count source
// - Alternate mode starts with receive level
// - Send-immediately bypasses FIFO for one byte
// - Direction output polarity set by invert
// - Line interrupt request on errors
module usr_regs #(
  parameter int FRAME_CYC = usr_pkg::FRAME_CYC,
  parameter int LVL_W = 7
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [usr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [usr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [usr_pkg::DATA_W-1:0] reg_rdata,
  // Receive datapath
  input wire logic rx_char_done,
  input wire logic rx_char_par_err,
  input wire logic rx_char_frm_err,
  input wire logic rx_fifo_full,
  input wire logic rx_pop,
  input wire logic rx_pop_err,
  input wire logic rx_head_valid,
  input wire logic rx_head_par,
  input wire logic rx_head_frm,
  input wire logic rx_head_brk,
  input wire logic [LVL_W-1:0] rx_level,
  output logic rx_fifo_push,
  output logic brk_load,
  // Transmit datapath
  input wire logic host_thr_wr,
  input wire logic tsr_load,
  input wire logic tsr_busy,
  input wire logic tx_bypass_sent,
  input wire logic [LVL_W-1:0] tx_level,
  output logic tx_bypass,
  output logic tx_hold,
  // Feature outputs
  output logic tx_disable,
  output logic rx_disable,
  output logic nine_bit,
  output logic fast_ir,
  // Line pins
  input wire logic rx_pin,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic rts_n,
  // Interrupt requests
  output logic line_irq_req,
  output logic modem_irq_req
);
  localparam int BC_W = $clog2(FRAME_CYC + 1);
  localparam logic [BC_W-1:0] BRK_LAST = BC_W'(FRAME_CYC - 1);

  logic [4:0] pin_s1_r, pin_s2_r;
  logic rx_s, cts_s, dsr_s, ri_s, cd_s;
  logic [7:0] ctrl_r, mctl_r, scr_r, feat_r, emode_r;
  logic [7:0] line_val, modem_val, scr_val;
  logic [3:0] lvl_r, lvl_prev_r, delta_r, delta_set;
  logic ovr_r, brk_hold_r, thr_full_r, alt_tx_r, snow_r, byp_used_r;
  logic [BC_W-1:0] low_cnt_r;
  logic [LVL_W-1:0] err_cnt_r;
  logic thre, temt, wr_line, rd_line, rd_modem, rd_scr, wr_scr;
  logic efr_on, swap_on, push_ok, brk_hit, tag_push_r;

  assign efr_on = ctrl_r[usr_pkg::CT_EFR];
  assign swap_on = ctrl_r[usr_pkg::CT_SWAP];
  assign wr_line = reg_wr && reg_addr == usr_pkg::ADDR_MODEM;
  assign rd_line = reg_rd && reg_addr == usr_pkg::ADDR_LINE;
  assign rd_modem = reg_rd && reg_addr == usr_pkg::ADDR_MODEM;
  assign rd_scr = reg_rd && reg_addr == usr_pkg::ADDR_SCR;
  assign wr_scr = reg_wr && reg_addr == usr_pkg::ADDR_SCR;

  // Pins are asynchronous; only the second stage is read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 5'h1F;
      pin_s2_r <= 5'h1F;
    end else begin
      pin_s1_r <= {cd_n, ri_n, dsr_n, cts_n, rx_pin};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign {cd_s, ri_s, dsr_s, cts_s, rx_s} = pin_s2_r;

  // Plain control registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= usr_pkg::ZERO8;
      mctl_r <= usr_pkg::ZERO8;
    end else if (reg_wr) begin
      if (reg_addr == usr_pkg::ADDR_CTRL)
        ctrl_r <= reg_wdata;
      if (reg_addr == usr_pkg::ADDR_MCTL)
        mctl_r <= reg_wdata;
    end
  end

  // features only change with enhanced enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      feat_r <= usr_pkg::ZERO8;
    else if (wr_line && efr_on)
      feat_r <= {reg_wdata[7:4], 4'h0};
  end

  // swap steers writes to the mode register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scr_r <= usr_pkg::SCR_RST;
      emode_r <= usr_pkg::ZERO8;
    end else if (wr_scr) begin
      if (swap_on)
        emode_r <= reg_wdata;
      else
        scr_r <= reg_wdata;
    end
  end

  // alternate sequence restarts on every mode write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      alt_tx_r <= 1'b0;
    else if (wr_scr && swap_on)
      alt_tx_r <= 1'b0;
    else if (rd_scr && swap_on && emode_r[1:0] == usr_pkg::EM_LVL_ALT)
      alt_tx_r <= ~alt_tx_r;
  end

  // one bypass per arming; self-clears when that byte is sent
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      snow_r <= 1'b0;
      byp_used_r <= 1'b0;
      tx_bypass <= 1'b0;
    end else begin
      tx_bypass <= host_thr_wr && ctrl_r[usr_pkg::CT_FIFO] && snow_r &&
                   !byp_used_r;
      if (tx_bypass_sent) begin
        snow_r <= 1'b0;
        byp_used_r <= 1'b0;
      end else begin
        if (wr_scr && swap_on)
          snow_r <= reg_wdata[usr_pkg::EM_SNOW];
        if (tx_bypass)
          byp_used_r <= 1'b1;
      end
    end
  end

  // full FIFO drops the new character and flags overrun
  assign push_ok = rx_char_done && !feat_r[usr_pkg::FW_RXDIS];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovr_r <= 1'b0;
      rx_fifo_push <= 1'b0;
      tag_push_r <= 1'b0;
    end else begin
      rx_fifo_push <= push_ok && !rx_fifo_full;
      // Tags only stand beside the done pulse
      tag_push_r <= push_ok && !rx_fifo_full &&
                    (rx_char_par_err || rx_char_frm_err);
      if (push_ok && rx_fifo_full)
        ovr_r <= 1'b1;
      else if (rd_line)
        ovr_r <= 1'b0;
    end
  end

  // a full frame low gives one break load, held until mark
  assign brk_hit = !rx_s && !brk_hold_r && low_cnt_r == BRK_LAST;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= '0;
      brk_hold_r <= 1'b0;
      brk_load <= 1'b0;
    end else begin
      brk_load <= brk_hit && !feat_r[usr_pkg::FW_RXDIS];
      if (rx_s) begin
        low_cnt_r <= '0;
        brk_hold_r <= 1'b0;
      end else if (brk_hit)
        brk_hold_r <= 1'b1;
      else if (!brk_hold_r)
        low_cnt_r <= low_cnt_r + 1'b1;
    end
  end

  // count of tagged bytes inside the receive FIFO
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      err_cnt_r <= '0;
    else
      err_cnt_r <= err_cnt_r +
        LVL_W'(tag_push_r) +
        LVL_W'(brk_load) - LVL_W'(rx_pop && rx_pop_err);
  end

  // host load fills the holding stage, shift load empties it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      thr_full_r <= 1'b0;
    else if (host_thr_wr)
      thr_full_r <= 1'b1;
    else if (tsr_load)
      thr_full_r <= 1'b0;
  end
  // FIFO mode looks at the transmit level instead
  assign thre = ctrl_r[usr_pkg::CT_FIFO] ? tx_level == '0 : !thr_full_r;
  assign temt = thre && !tsr_busy;

  always_comb begin
    line_val = usr_pkg::ZERO8;
    line_val[usr_pkg::LS_DR] = rx_head_valid;
    line_val[usr_pkg::LS_OVR] = ovr_r;
    // tags of the character at the head; break also while a held break lasts
    line_val[usr_pkg::LS_PAR] = rx_head_valid && rx_head_par;
    line_val[usr_pkg::LS_FRM] = rx_head_valid && rx_head_frm;
    line_val[usr_pkg::LS_BRK] = (rx_head_valid && rx_head_brk) || brk_hold_r;
    line_val[usr_pkg::LS_THRE] = thre;
    line_val[usr_pkg::LS_TEMT] = temt;
    line_val[usr_pkg::LS_FERR] = err_cnt_r != '0;
  end

  // live levels, or modem control bits in loopback
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvl_r <= 4'h0;
      lvl_prev_r <= 4'h0;
    end else begin
      lvl_prev_r <= lvl_r;
      if (mctl_r[usr_pkg::MC_LOOP])
        lvl_r <= {mctl_r[usr_pkg::MC_OP2], mctl_r[usr_pkg::MC_OP1],
                  mctl_r[usr_pkg::MC_DTR], mctl_r[usr_pkg::MC_RTS]};
      else
        lvl_r <= ~{cd_s, ri_s, dsr_s, cts_s};
    end
  end

  always_comb begin
    // any change of CTS, DSR or CD
    delta_set[0] = lvl_r[0] ^ lvl_prev_r[0];
    delta_set[1] = lvl_r[1] ^ lvl_prev_r[1];
    delta_set[3] = lvl_r[3] ^ lvl_prev_r[3];
    // ring input rising means status bit falling
    delta_set[2] = lvl_prev_r[2] && !lvl_r[2];
  end

  // read clears, but a change in the same cycle survives
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      delta_r <= 4'h0;
    else
      delta_r <= (rd_modem ? 4'h0 : delta_r) | delta_set;
  end
  assign modem_val = {lvl_r, delta_r};

  always_comb begin
    scr_val = scr_r;
    if (swap_on) begin
      if (!emode_r[0])
        scr_val = 8'(rx_level);
      else if (emode_r[1:0] == usr_pkg::EM_LVL_TX || alt_tx_r)
        scr_val = 8'(tx_level);
      else
        scr_val = 8'(rx_level);
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      reg_rdata <= usr_pkg::ZERO8;
    else if (!reg_rd)
      reg_rdata <= usr_pkg::ZERO8;
    else begin
      unique case (reg_addr)
        usr_pkg::ADDR_CTRL: reg_rdata <= ctrl_r;
        usr_pkg::ADDR_MCTL: reg_rdata <= mctl_r;
        usr_pkg::ADDR_LINE: reg_rdata <= line_val;
        usr_pkg::ADDR_MODEM: reg_rdata <= modem_val;
        usr_pkg::ADDR_SCR: reg_rdata <= scr_val;
        default: reg_rdata <= usr_pkg::ZERO8;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_hold <= 1'b0;
      rts_n <= 1'b1;
      line_irq_req <= 1'b0;
      modem_irq_req <= 1'b0;
      {fast_ir, nine_bit, rx_disable, tx_disable} <= 4'h0;
    end else begin
      // engine finishes its character, then waits
      tx_hold <= ctrl_r[usr_pkg::CT_ACTS] && cts_s;
      if (ctrl_r[usr_pkg::CT_R485])
        rts_n <= emode_r[usr_pkg::EM_RINV] ^ temt;
      else
        rts_n <= ~mctl_r[usr_pkg::MC_RTS];
      // overrun at once, errors once at the head
      line_irq_req <= ctrl_r[usr_pkg::CT_LSIE] &&
                      (|line_val[usr_pkg::LS_BRK:usr_pkg::LS_OVR]);
      // modem request while any delta stands
      modem_irq_req <= ctrl_r[usr_pkg::CT_MSIE] && (|delta_r);
      {fast_ir, nine_bit, rx_disable, tx_disable} <= feat_r[7:4];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_ovr;
    rx_char_done && rx_fifo_full && !feat_r[usr_pkg::FW_RXDIS] |=>
      ovr_r && !rx_fifo_push;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun lost");

  property p_par;
    rd_line && rx_head_valid && rx_head_par |=> reg_rdata[usr_pkg::LS_PAR];
  endproperty
  a_par: assert property (p_par) else $error("parity tag lost");

  property p_frm;
    rd_line && !rx_head_frm |=> !reg_rdata[usr_pkg::LS_FRM];
  endproperty
  a_frm: assert property (p_frm) else $error("false framing");

  property p_brk_once;
    brk_load |=> !brk_load && brk_hold_r;
  endproperty
  a_brk_once: assert property (p_brk_once) else $error("two breaks");

  property p_temt;
    tsr_busy |-> !temt;
  endproperty
  a_temt: assert property (p_temt) else $error("idle while busy");

  property p_ferr;
    err_cnt_r == '0 |-> !line_val[usr_pkg::LS_FERR];
  endproperty
  a_ferr: assert property (p_ferr) else $error("stale fifo error");

  property p_ri;
    !lvl_prev_r[2] && !rd_modem && !delta_r[2] |=> !delta_r[2];
  endproperty
  a_ri: assert property (p_ri) else $error("ring delta on fall");

  property p_clr;
    rd_modem && delta_set == 4'h0 |=> delta_r == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("delta not cleared");

  property p_scr;
    wr_scr && !swap_on ##1 rd_scr && !swap_on |=> reg_rdata == $past(scr_r);
  endproperty
  a_scr: assert property (p_scr) else $error("scratch lost");

  c_ovr: cover property (rx_char_done && rx_fifo_full);
  c_brk: cover property (brk_load);
  c_alt: cover property (rd_scr && alt_tx_r);
  c_byp: cover property (tx_bypass ##[1:20] tx_bypass_sent);
endmodule

// [inc/usr_pkg.sv]
package usr_pkg;
  // Register map and widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_MCTL = 3'h4;
  localparam logic [2:0] ADDR_LINE = 3'h5;
  localparam logic [2:0] ADDR_MODEM = 3'h6;
  localparam logic [2:0] ADDR_SCR = 3'h7;
  // Control register fields
  localparam int CT_EFR = 0;
  localparam int CT_FIFO = 1;
  localparam int CT_ACTS = 2;
  localparam int CT_R485 = 3;
  localparam int CT_SWAP = 4;
  localparam int CT_LSIE = 5;
  localparam int CT_MSIE = 6;
  // Modem control fields
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_OP1 = 2;
  localparam int MC_OP2 = 3;
  localparam int MC_LOOP = 4;
  // Line status fields
  localparam int LS_DR = 0;
  localparam int LS_OVR = 1;
  localparam int LS_PAR = 2;
  localparam int LS_FRM = 3;
  localparam int LS_BRK = 4;
  localparam int LS_THRE = 5;
  localparam int LS_TEMT = 6;
  localparam int LS_FERR = 7;
  // Modem status fields, deltas in 3:0, levels in 7:4
  localparam int MS_DCTS = 0;
  localparam int MS_DDSR = 1;
  localparam int MS_TERI = 2;
  localparam int MS_DCD = 3;
  localparam int MS_CTS = 4;
  localparam int MS_DSR = 5;
  localparam int MS_RI = 6;
  localparam int MS_CD = 7;
  // Feature write port fields
  localparam int FW_TXDIS = 4;
  localparam int FW_RXDIS = 5;
  localparam int FW_NINE = 6;
  localparam int FW_FIR = 7;
  // Enhanced mode fields
  localparam int EM_SNOW = 2;
  localparam int EM_RINV = 3;
  localparam logic [1:0] EM_LVL_TX = 2'h1;
  localparam logic [1:0] EM_LVL_ALT = 2'h3;
  // Reset values
  localparam logic [7:0] SCR_RST = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Break detection: one 10-bit frame at 9600 baud
  localparam int CLK_NS = 40;
  localparam int FRAME_US = 1042;
  localparam int FRAME_CYC = (FRAME_US * 1000 + CLK_NS - 1) / CLK_NS;
endpackage

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
  logic sys_clk = 0;
  logic rst = 1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] d;
  logic reg_wr = 0, reg_rd = 0;
  logic rx_char_done = 0, rx_char_par_err = 0, rx_char_frm_err = 0;
  logic rx_fifo_full = 0, rx_pop = 0, rx_pop_err = 0, rx_head_valid = 0;
  logic rx_head_par = 0, rx_head_frm = 0, rx_head_brk = 0;
  logic [6:0] rx_level = 7'h05;
  logic [6:0] tx_level = 7'h00;
  logic host_thr_wr = 0, tsr_load = 0, tsr_busy = 0, tx_bypass_sent = 0;
  logic rx_fifo_push, brk_load, tx_bypass, tx_hold, tx_disable, rx_disable;
  logic nine_bit, fast_ir, rx_pin, cts_n, dsr_n, ri_n, cd_n, rts_n;
  logic line_irq_req, modem_irq_req;
  logic brk_go = 0;
  logic [3:0] lvl_n = 4'hF;
  int failures = 0;
  int tests_run = 0;
  int brks = 0;

  usr_regs #(.FRAME_CYC(20), .LVL_W(7)) i_usr_regs (.*);
  usr_peer #(.BRK_CYC(40)) i_usr_peer (.sys_clk(sys_clk), .lvl_n(lvl_n),
    .brk_go(brk_go), .rx_pin(rx_pin), .cts_n(cts_n), .dsr_n(dsr_n),
    .ri_n(ri_n), .cd_n(cd_n));

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (brk_load === 1'b1)
      brks++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Rx pulse helper, one cycle, push seen the cycle after
  task automatic rx_char(input logic full, input logic perr);
    @(posedge sys_clk);
    rx_fifo_full <= full;
    rx_char_par_err <= perr;
    rx_char_done <= 1'b1;
    @(posedge sys_clk);
    rx_char_done <= 1'b0;
    #1;
  endtask
  task automatic thr_wr();
    @(posedge sys_clk);
    host_thr_wr <= 1'b1;
    @(posedge sys_clk);
    host_thr_wr <= 1'b0;
    #1;
  endtask

  initial begin
    #2000000;
    failures++;
    final_report();
  end

  initial begin
    cyc(3);
    rst <= 1'b0;
    rd(usr_pkg::ADDR_SCR, d);
    chk("scratch reset", d, 8'hFF);
    wr(usr_pkg::ADDR_SCR, 8'h5A);
    rd(usr_pkg::ADDR_SCR, d);
    chk("scratch", d, 8'h5A);
    rd(3'h1, d);
    chk("unmapped", d, 8'h00);
    wr(usr_pkg::ADDR_CTRL, 8'h22);
    rx_char(1'b0, 1'b1);
    chk("push", 8'(rx_fifo_push), 8'h01);
    rx_char(1'b1, 1'b0);
    chk("push full", 8'(rx_fifo_push), 8'h00);
    cyc(2);
    #1 chk("line irq", 8'(line_irq_req), 8'h01);
    rd(usr_pkg::ADDR_LINE, d);
    chk("overrun and fifo err", d & 8'h82, 8'h82);
    rd(usr_pkg::ADDR_LINE, d);
    chk("overrun read", d & 8'h02, 8'h00);
    @(posedge sys_clk);
    rx_fifo_full <= 1'b0;
    rx_pop <= 1'b1;
    rx_pop_err <= 1'b1;
    @(posedge sys_clk);
    rx_pop <= 1'b0;
    rx_head_valid <= 1'b1;
    rx_head_par <= 1'b1;
    rd(usr_pkg::ADDR_LINE, d);
    chk("par tag", d & 8'h8D, 8'h05);
    @(posedge sys_clk);
    rx_head_par <= 1'b0;
    rx_head_frm <= 1'b1;
    rd(usr_pkg::ADDR_LINE, d);
    chk("frm tag", d & 8'h6D, 8'h69);
    @(posedge sys_clk);
    rx_head_frm <= 1'b0;
    tx_level <= 7'h01;
    rd(usr_pkg::ADDR_LINE, d);
    chk("tx not empty", d & 8'h60, 8'h00);
    @(posedge sys_clk);
    tx_level <= 7'h00;
    tsr_busy <= 1'b1;
    rd(usr_pkg::ADDR_LINE, d);
    chk("shift busy", d & 8'h60, 8'h20);
    wr(usr_pkg::ADDR_CTRL, 8'h0A);
    cyc(2);
    #1 chk("rts tx", 8'(rts_n), 8'h00);
    @(posedge sys_clk);
    tsr_busy <= 1'b0;
    cyc(2);
    #1 chk("rts rx", 8'(rts_n), 8'h01);
    wr(usr_pkg::ADDR_CTRL, 8'h1A);
    wr(usr_pkg::ADDR_SCR, 8'h08);
    cyc(2);
    #1 chk("rts inv", 8'(rts_n), 8'h00);
    @(posedge sys_clk);
    tx_level <= 7'h09;
    wr(usr_pkg::ADDR_SCR, 8'h02);
    rd(usr_pkg::ADDR_SCR, d);
    chk("rx count", d, 8'h05);
    wr(usr_pkg::ADDR_SCR, 8'h01);
    rd(usr_pkg::ADDR_SCR, d);
    chk("tx count", d, 8'h09);
    wr(usr_pkg::ADDR_SCR, 8'h03);
    for (int i = 0; i < 3; i++) begin
      rd(usr_pkg::ADDR_SCR, d);
      chk("alt count", d, i[0] ? 8'h09 : 8'h05);
    end
    wr(usr_pkg::ADDR_CTRL, 8'h12);
    wr(usr_pkg::ADDR_SCR, 8'h04);
    thr_wr();
    chk("bypass", 8'(tx_bypass), 8'h01);
    @(posedge sys_clk);
    tx_bypass_sent <= 1'b1;
    @(posedge sys_clk);
    tx_bypass_sent <= 1'b0;
    thr_wr();
    chk("bypass once", 8'(tx_bypass), 8'h00);
    wr(usr_pkg::ADDR_CTRL, 8'h02);
    rd(usr_pkg::ADDR_SCR, d);
    chk("scratch kept", d, 8'h5A);
    wr(usr_pkg::ADDR_MODEM, 8'hF0);
    cyc(1);
    #1 chk("feat locked", 8'({fast_ir, nine_bit, rx_disable, tx_disable}),
      8'h00);
    wr(usr_pkg::ADDR_CTRL, 8'h03);
    for (int i = 4; i < 8; i++) begin
      wr(usr_pkg::ADDR_MODEM, 8'h01 << i);
      cyc(1);
      #1 chk("feature", 8'({fast_ir, nine_bit, rx_disable, tx_disable}),
        8'h01 << (i - 4));
    end
    wr(usr_pkg::ADDR_MODEM, 8'h20);
    rx_char(1'b0, 1'b0);
    chk("rx off push", 8'(rx_fifo_push), 8'h00);
    wr(usr_pkg::ADDR_MODEM, 8'h00);
    wr(usr_pkg::ADDR_CTRL, 8'h42);
    @(posedge sys_clk);
    lvl_n <= 4'hE;
    cyc(8);
    #1 chk("modem irq", 8'(modem_irq_req), 8'h01);
    rd(usr_pkg::ADDR_MODEM, d);
    chk("cts delta", d, 8'h11);
    rd(usr_pkg::ADDR_MODEM, d);
    chk("delta clear", d, 8'h10);
    @(posedge sys_clk);
    lvl_n <= 4'h4;
    cyc(8);
    rd(usr_pkg::ADDR_MODEM, d);
    chk("dsr cd delta", d, 8'hBA);
    @(posedge sys_clk);
    lvl_n <= 4'h0;
    cyc(8);
    rd(usr_pkg::ADDR_MODEM, d);
    chk("ring start", d, 8'hF0);
    @(posedge sys_clk);
    lvl_n <= 4'h4;
    cyc(8);
    rd(usr_pkg::ADDR_MODEM, d);
    chk("ring end", d, 8'hB4);
    wr(usr_pkg::ADDR_MCTL, 8'h1F);
    rd(usr_pkg::ADDR_MODEM, d);
    chk("loop all", d & 8'hF0, 8'hF0);
    wr(usr_pkg::ADDR_MCTL, 8'h15);
    rd(usr_pkg::ADDR_MODEM, d);
    chk("loop dtr op1", d & 8'hF0, 8'h60);
    wr(usr_pkg::ADDR_MCTL, 8'h00);
    wr(usr_pkg::ADDR_CTRL, 8'h06);
    @(posedge sys_clk);
    lvl_n <= 4'h5;
    cyc(8);
    #1 chk("tx hold", 8'(tx_hold), 8'h01);
    @(posedge sys_clk);
    lvl_n <= 4'h4;
    cyc(8);
    #1 chk("tx resume", 8'(tx_hold), 8'h00);
    @(posedge sys_clk);
    brk_go <= 1'b1;
    @(posedge sys_clk);
    brk_go <= 1'b0;
    cyc(30);
    rd(usr_pkg::ADDR_LINE, d);
    chk("break held", d & 8'h10, 8'h10);
    cyc(20);
    rd(usr_pkg::ADDR_LINE, d);
    chk("break gone", d & 8'h10, 8'h00);
    chk("break loads", 8'(brks), 8'h01);
    final_report();
  end
endmodule

// [tb/usr_peer.sv]
`timescale 1ns/10ps
module usr_peer #(
  parameter int BRK_CYC = 40
) (
  // Clock
  input wire logic sys_clk,
  // Bench requests
  input wire logic [3:0] lvl_n,
  input wire logic brk_go,
  // Line pins
  output logic rx_pin,
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic cd_n
);
  logic [3:0] lvl_q = 4'hF;
  int cnt = 0;
  always @(posedge sys_clk) begin
    lvl_q <= lvl_n;
  end
  assign {cd_n, ri_n, dsr_n, cts_n} = lvl_q;
  // line held low past a frame
  always @(posedge sys_clk) begin
    if (brk_go)
      cnt <= BRK_CYC;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign rx_pin = (cnt == 0);
endmodule
